// [common/prm_pkg.sv]
// shared constants and types for the pipelined read master
package prm_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_BASE      = 8'h04;
  localparam logic [7:0] OFS_LEN       = 8'h08;
  localparam logic [7:0] OFS_STATUS    = 8'h0c;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h14;
  localparam logic [7:0] OFS_FIFO_DATA = 8'h18;
  // field positions
  localparam int CTRL_START_BIT = 0;
  localparam int ST_DONE_BIT    = 0;
  localparam int ST_BUSY_BIT    = 1;
  localparam int ST_EMPTY_BIT   = 2;
  localparam int ST_LEVEL_LSB   = 8;
  localparam int IRQ_DONE_BIT   = 0;
  localparam int IRQ_DATA_BIT   = 1;
  // reset values
  localparam logic [31:0] RST_BASE = 32'h0000_0000;
  localparam logic [31:0] RST_LEN  = 32'h0000_0000;
  localparam logic [1:0]  RST_IRQ  = 2'h0;
  // word and fifo geometry
  localparam logic [31:0] WORD_BYTES  = 32'h0000_0004;
  localparam logic [3:0]  BYTE_EN_ALL = 4'hf;
  localparam int          FIFO_DEPTH  = 16;
  localparam int          FIFO_THRESH = 12;
  localparam int          FIFO_AW     = 4;
  localparam int          CNT_W       = 5;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // transfer sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_ISSUE = 3'h2,
    ST_DRAIN = 3'h4
  } prm_state_t;
endpackage : prm_pkg

// [hdl/prm_fifo_mem.sv]
// receive buffer storage with registered read port
`timescale 1ns/1ps
module prm_fifo_mem #(
  parameter int W     = 32,
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // clock and reset
  input  wire logic          clk,
  input  wire logic          resetn,
  // write side
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire logic [W-1:0]  wr_data,
  // read side
  input  wire logic [AW-1:0] rd_addr,
  output logic      [W-1:0]  rd_data_ff
);
  logic [W-1:0] mem [DEPTH];  // storage array, no reset needed

  // write port
  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read port, always follows the read address
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_data_ff <= '0;
    end else begin
      rd_data_ff <= mem[rd_addr];
    end
  end
endmodule : prm_fifo_mem

// [hdl/prm_read_master.sv]
// pipelined read master with receive fifo and axi4-lite control
//
// Contract
// - hold request and address during waitrequest
// - post back-to-back reads while not stalled
// - address comes from a stable register
// - capture return data only when valid
// - stop requesting at fifo fill threshold
// - start latches base and byte count
// - issue reads from next cycle until done
// - address plus four, length minus four
// - update only on posted read, length nonzero
// - posted means read high, waitrequest low
// - outstanding count up on post without return
// - outstanding count down on return without post
// - reads in flight fit free fifo space
// - done only when length and outstanding zero
`timescale 1ns/1ps
module prm_read_master #(
  parameter int DEPTH  = prm_pkg::FIFO_DEPTH,
  parameter int THRESH = prm_pkg::FIFO_THRESH
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // axi4-lite slave
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  output logic      [1:0]  s_bresp,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  input  wire logic [7:0]  s_araddr,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  output logic      [31:0] s_rdata,
  output logic      [1:0]  s_rresp,
  // memory-mapped read master
  output logic             mm_read,
  output logic      [31:0] mm_address,
  output logic      [3:0]  mm_byteenable,
  input  wire logic        mm_waitrequest,
  input  wire logic [31:0] mm_readdata,
  input  wire logic        mm_readdatavalid,
  // interrupt
  output logic             irq
);
  import prm_pkg::*;

  prm_state_t           state_ff;                 // transfer sequencer
  logic                 read_ff;                  // read request
  logic [31:0]          addr_ff;                  // address register
  logic [31:0]          len_ff;                   // bytes left to post
  logic [CNT_W-1:0]     outs_ff;                  // reads in flight
  logic [CNT_W-1:0]     fcnt_ff;                  // fifo fill level
  logic [FIFO_AW-1:0]   wptr_ff, rptr_ff;         // fifo pointers
  logic                 done_ff;                  // completion flag
  logic [31:0]          base_ff, cfg_len_ff;      // software setup
  logic [1:0]           istat_ff, imask_ff;       // interrupt bits
  logic                 irq_ff;
  logic                 aw_held_ff, w_held_ff;    // write channel holds
  logic [7:0]           awaddr_ff, araddr_ff;
  logic [31:0]          wdata_ff;
  logic [3:0]           wstrb_ff;
  logic                 awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  logic [1:0]           bresp_ff, rresp_ff;
  logic [31:0]          rdata_ff;
  logic                 rd_pend_ff, rd_fifo_ok_ff; // read pipeline stage
  logic [31:0]          mem_q;                    // fifo head word

  // combinational terms
  logic                 posted, push, pop, do_write, start_acc;
  logic                 ar_take, aw_take, w_take, nxt_rvalid, nxt_aw_held, nxt_w_held;
  logic [CNT_W-1:0]     nxt_outs, nxt_fcnt;
  logic [31:0]          nxt_len;
  logic                 room;
  logic [1:0]           ev_set, ev_clr;

  // byte-lane merge for strobed register writes
  function automatic logic [31:0] prm_merge(input logic [31:0] old,
                                            input logic [31:0] nw,
                                            input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : prm_merge

  assign aw_take  = s_awvalid & awready_ff;
  assign w_take   = s_wvalid & wready_ff;
  assign ar_take  = s_arvalid & arready_ff;
  // both halves present and the previous response gone
  assign do_write = aw_held_ff & w_held_ff & ~bvalid_ff;
  // a start written while busy is ignored so a live transfer is never torn
  assign start_acc = do_write & (awaddr_ff == OFS_CTRL) & wstrb_ff[0]
                   & wdata_ff[CTRL_START_BIT] & (state_ff == ST_IDLE);
  assign posted = read_ff & ~mm_waitrequest;
  assign push   = mm_readdatavalid;
  assign pop    = rd_pend_ff & rd_fifo_ok_ff;

  // counters and length for the coming cycle
  always_comb begin
    if (posted && !push) begin
      nxt_outs = outs_ff + 1'b1;
    end else if (!posted && push) begin
      nxt_outs = outs_ff - 1'b1;
    end else begin
      nxt_outs = outs_ff;
    end
    nxt_fcnt = fcnt_ff + CNT_W'(push) - CNT_W'(pop);
    if (posted && len_ff != 32'h0) begin
      nxt_len = len_ff - WORD_BYTES;
    end else begin
      nxt_len = len_ff;
    end
    // in flight plus stored within threshold
    room = ({1'b0, nxt_fcnt} + {1'b0, nxt_outs}) < (CNT_W+1)'(THRESH);
  end

  // sequencer, request, address and length
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
      read_ff  <= 1'b0;
      addr_ff  <= RST_BASE;
      len_ff   <= RST_LEN;
    end else begin
      case (state_ff)
        ST_IDLE: begin
          if (start_acc) begin
            addr_ff <= base_ff;
            len_ff  <= cfg_len_ff;
            read_ff  <= (cfg_len_ff != 32'h0);
            state_ff <= (cfg_len_ff != 32'h0) ? ST_ISSUE : ST_DRAIN;
          end
        end
        ST_ISSUE: begin
          if (posted && len_ff != 32'h0) begin
            addr_ff <= addr_ff + WORD_BYTES;
          end
          len_ff <= nxt_len;
          if (read_ff && mm_waitrequest) begin
            read_ff <= 1'b1;
          end else begin
            read_ff <= (nxt_len != 32'h0) & room;
          end
          if (nxt_len == 32'h0 && !(read_ff && mm_waitrequest)) begin
            state_ff <= ST_DRAIN;
          end
        end
        ST_DRAIN: begin
          // wait for the last return
          read_ff <= 1'b0;
          if (nxt_outs == '0) begin
            state_ff <= ST_IDLE;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
          read_ff  <= 1'b0;
        end
      endcase
    end
  end

  // outstanding and fill counters
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      outs_ff <= '0;
      fcnt_ff <= '0;
      wptr_ff <= '0;
      rptr_ff <= '0;
    end else begin
      outs_ff <= nxt_outs;
      fcnt_ff <= nxt_fcnt;
      if (push) begin
        wptr_ff <= wptr_ff + 1'b1;
      end
      if (pop) begin
        rptr_ff <= rptr_ff + 1'b1;
      end
    end
  end

  // completion flag
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_ff <= 1'b0;
    end else if (start_acc) begin
      done_ff <= 1'b0;
    end else if (state_ff == ST_DRAIN && len_ff == 32'h0 && nxt_outs == '0) begin
      done_ff <= 1'b1;
    end
  end

  // receive fifo storage
  prm_fifo_mem #(.W(32), .DEPTH(DEPTH), .AW(FIFO_AW)) u_mem (
    .clk        (clk),
    .resetn     (resetn),
    .wr_en      (push),
    .wr_addr    (wptr_ff),
    .wr_data    (mm_readdata),
    .rd_addr    (rptr_ff),
    .rd_data_ff (mem_q)
  );

  // write channel capture, address and data taken in either order
  assign nxt_aw_held = do_write ? 1'b0 : (aw_held_ff | aw_take);
  assign nxt_w_held  = do_write ? 1'b0 : (w_held_ff | w_take);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= '0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= RESP_OKAY;
    end else begin
      aw_held_ff <= nxt_aw_held;
      w_held_ff  <= nxt_w_held;
      awready_ff <= ~nxt_aw_held;
      wready_ff  <= ~nxt_w_held;
      if (aw_take) begin
        awaddr_ff <= s_awaddr;
      end
      if (w_take) begin
        wdata_ff <= s_wdata;
        wstrb_ff <= s_wstrb;
      end
      if (do_write) begin
        bvalid_ff <= 1'b1;
        bresp_ff  <= (awaddr_ff <= OFS_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  // software setup registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      base_ff    <= RST_BASE;
      cfg_len_ff <= RST_LEN;
      imask_ff   <= RST_IRQ;
    end else if (do_write) begin
      case (awaddr_ff)
        OFS_BASE:     base_ff    <= prm_merge(base_ff, wdata_ff, wstrb_ff);
        OFS_LEN:      cfg_len_ff <= prm_merge(cfg_len_ff, wdata_ff, wstrb_ff);
        OFS_IRQ_MASK: if (wstrb_ff[0]) imask_ff <= wdata_ff[1:0];
        default:      imask_ff   <= imask_ff;
      endcase
    end
  end

  // sticky events, a set in the clearing cycle wins
  assign ev_set = {push, state_ff == ST_DRAIN && len_ff == 32'h0 && nxt_outs == '0};
  assign ev_clr = (do_write && awaddr_ff == OFS_IRQ_STAT && wstrb_ff[0]) ? wdata_ff[1:0] : 2'h0;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      istat_ff <= RST_IRQ;
      irq_ff   <= 1'b0;
    end else begin
      istat_ff <= (istat_ff & ~ev_clr) | ev_set;
      irq_ff   <= |(((istat_ff & ~ev_clr) | ev_set) & imask_ff);
    end
  end

  // read channel: address taken, one stage, then data
  assign nxt_rvalid = rd_pend_ff | (rvalid_ff & ~s_rready);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      arready_ff    <= 1'b0;
      araddr_ff     <= '0;
      rd_pend_ff    <= 1'b0;
      rd_fifo_ok_ff <= 1'b0;
      rvalid_ff     <= 1'b0;
      rdata_ff      <= '0;
      rresp_ff      <= RESP_OKAY;
    end else begin
      arready_ff <= ~ar_take & ~nxt_rvalid & ~rd_pend_ff;
      rd_pend_ff <= ar_take;
      rvalid_ff  <= nxt_rvalid;
      if (ar_take) begin
        araddr_ff <= s_araddr;
        // head word is only trusted if it was stored before this edge
        rd_fifo_ok_ff <= (s_araddr == OFS_FIFO_DATA) && (fcnt_ff != '0);
      end
      if (rd_pend_ff) begin
        rresp_ff <= RESP_OKAY;
        case (araddr_ff)
          OFS_CTRL:      rdata_ff <= 32'h0;
          OFS_BASE:      rdata_ff <= base_ff;
          OFS_LEN:       rdata_ff <= cfg_len_ff;
          OFS_STATUS:    rdata_ff <= {19'h0, fcnt_ff, 5'h0, fcnt_ff == '0,
                                      state_ff != ST_IDLE, done_ff};
          OFS_IRQ_STAT:  rdata_ff <= {30'h0, istat_ff};
          OFS_IRQ_MASK:  rdata_ff <= {30'h0, imask_ff};
          OFS_FIFO_DATA: rdata_ff <= rd_fifo_ok_ff ? mem_q : 32'h0;
          default: begin
            rdata_ff <= 32'h0;
            rresp_ff <= RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // outputs straight from flops, except byte enables tied to all ones
  assign s_awready     = awready_ff;
  assign s_wready      = wready_ff;
  assign s_bvalid      = bvalid_ff;
  assign s_bresp       = bresp_ff;
  assign s_arready     = arready_ff;
  assign s_rvalid      = rvalid_ff;
  assign s_rdata       = rdata_ff;
  assign s_rresp       = rresp_ff;
  assign mm_read       = read_ff;
  assign mm_address    = addr_ff;
  assign mm_byteenable = BYTE_EN_ALL;
  assign irq           = irq_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  hold_on_wait_a: assert property (read_ff && mm_waitrequest |=> read_ff
    && $stable(addr_ff)) else $error("request dropped during wait");
  addr_step_a: assert property (posted && len_ff != 0 |=> addr_ff
    == $past(addr_ff) + 32'h4 && len_ff == $past(len_ff) - 32'h4) else $error("bad step");
  len_hold_a: assert property (!posted && !start_acc |=> $stable(len_ff))
    else $error("length moved without post");
  push_gate_a: assert property (!mm_readdatavalid |=> $stable(wptr_ff))
    else $error("fifo written without valid");
  no_overflow_a: assert property (fcnt_ff + outs_ff <= CNT_W'(THRESH))
    else $error("reads exceed fifo space");
  start_latch_a: assert property (start_acc && cfg_len_ff != 0 |=> read_ff
    && addr_ff == $past(base_ff) && len_ff == $past(cfg_len_ff)) else $error("start lost");
  outs_inc_a: assert property (posted && !mm_readdatavalid |=>
    outs_ff == $past(outs_ff) + 1'b1) else $error("count not raised");
  outs_dec_a: assert property (!posted && mm_readdatavalid |=>
    outs_ff == $past(outs_ff) - 1'b1) else $error("count not lowered");
  done_cond_a: assert property (done_ff |-> len_ff == 0 && outs_ff == 0)
    else $error("done with reads pending");
  done_clear_a: assert property (start_acc |=> !done_ff)
    else $error("done not cleared");

  start_seen_c:  cover property (start_acc ##1 read_ff);
  stall_seen_c:  cover property (read_ff && mm_waitrequest [*3]);
  full_seen_c:   cover property (fcnt_ff == CNT_W'(THRESH));
  done_seen_c:   cover property ($rose(done_ff));
endmodule : prm_read_master

// [tb/prm_mem_model.sv]
// pipelined memory slave standing behind the read master port
`timescale 1ns/1ps
module prm_mem_model #(
  parameter logic [31:0] KEY = 32'hc3c3_0000
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // bench knobs
  input  wire logic        slow,
  input  wire logic        ret_en,
  // read port
  input  wire logic        mm_read,
  input  wire logic [31:0] mm_address,
  output logic             mm_waitrequest,
  output logic      [31:0] mm_readdata,
  output logic             mm_readdatavalid
);
  logic [31:0] pend_q[$];  // posted addresses awaiting return
  logic [1:0]  cnt_ff;     // free-running pattern for slow mode

  // stall every other cycle in slow mode
  assign mm_waitrequest = slow & cnt_ff[0];

  // accept posts, return in order; idle data toggles so stale data never looks valid
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cnt_ff           <= 2'h0;
      mm_readdatavalid <= 1'b0;
      mm_readdata      <= 32'h0;
      pend_q.delete();
    end else begin
      cnt_ff <= cnt_ff + 2'h1;
      if (mm_read && !mm_waitrequest) begin
        pend_q.push_back(mm_address);
      end
      if (pend_q.size() > 0 && ret_en && !(slow && cnt_ff[1])) begin
        mm_readdatavalid <= 1'b1;
        mm_readdata      <= pend_q.pop_front() ^ KEY;
      end else begin
        mm_readdatavalid <= 1'b0;
        mm_readdata      <= ~mm_readdata;
      end
    end
  end
endmodule : prm_mem_model

// [tb/tb_prm_read_master.sv]
// self-checking bench for the pipelined read master
`timescale 1ns/1ps
module tb_prm_read_master;
  import prm_pkg::*;
  localparam int          THR = 12;             // fill threshold under test
  localparam logic [31:0] KEY = 32'hc3c3_0000;  // model data scramble
  logic        clk = 1'b0, resetn = 1'b0;
  logic        s_awvalid = 1'b0, s_wvalid = 1'b0, s_bready = 1'b0;
  logic        s_arvalid = 1'b0, s_rready = 1'b0;
  logic [7:0]  s_awaddr = 8'h0, s_araddr = 8'h0;
  logic [31:0] s_wdata = 32'h0;
  logic        s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
  logic [1:0]  s_bresp, s_rresp;
  logic [31:0] s_rdata, mm_address, mm_readdata;
  logic        mm_read, mm_waitrequest, mm_readdatavalid;
  logic [3:0]  mm_byteenable;
  logic        slow = 1'b0, ret_en = 1'b1;
  logic        held = 1'b0;
  logic [31:0] held_addr = 32'h0, exp_addr = 32'h0;
  int          failures = 0, num_checks = 0;
  int          posts = 0, p_mark = 0, cyc = 0, t_first = 0, t_last = 0;

  always #2.5 clk = ~clk;

  prm_read_master #(.DEPTH(16), .THRESH(THR)) u_dut (
    .clk(clk), .resetn(resetn),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_awaddr(s_awaddr),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_wdata(s_wdata), .s_wstrb(4'hf),
    .s_bvalid(s_bvalid), .s_bready(s_bready), .s_bresp(s_bresp),
    .s_arvalid(s_arvalid), .s_arready(s_arready), .s_araddr(s_araddr),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .mm_read(mm_read), .mm_address(mm_address), .mm_byteenable(mm_byteenable),
    .mm_waitrequest(mm_waitrequest), .mm_readdata(mm_readdata),
    .mm_readdatavalid(mm_readdatavalid), .irq(irq));

  prm_mem_model #(.KEY(KEY)) u_mem (
    .clk(clk), .resetn(resetn), .slow(slow), .ret_en(ret_en),
    .mm_read(mm_read), .mm_address(mm_address), .mm_waitrequest(mm_waitrequest),
    .mm_readdata(mm_readdata), .mm_readdatavalid(mm_readdatavalid));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict;
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict

  // write: offer both halves, drop each once taken, keep bready until bvalid
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge clk);
    s_awvalid <= 1'b1;
    s_awaddr  <= a;
    s_wvalid  <= 1'b1;
    s_wdata   <= d;
    s_bready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_awvalid && s_awready) s_awvalid <= 1'b0;
      if (s_wvalid && s_wready) s_wvalid <= 1'b0;
    end while (!(s_bvalid && s_bready) && n < 100);
    if (n >= 100) failures++;
    s_bready <= 1'b0;
    chk({30'h0, s_bresp}, {30'h0, er});
  endtask : axi_wr

  // read: data taken at the edge that sees rvalid with rready
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    s_arvalid <= 1'b1;
    s_araddr  <= a;
    s_rready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (s_arvalid && s_arready) s_arvalid <= 1'b0;
    end while (!(s_rvalid && s_rready) && n < 100);
    if (n >= 100) failures++;
    d = s_rdata;
    // offsets up to the fifo data port answer okay, higher ones slave error
    if (a <= OFS_FIFO_DATA) begin
      chk({30'h0, s_rresp}, {30'h0, RESP_OKAY});
    end else begin
      chk({30'h0, s_rresp}, {30'h0, RESP_SLVERR});
    end
    s_rready <= 1'b0;
  endtask : axi_rd

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    axi_rd(a, v);
    chk(v, exp);
  endtask : rd_chk

  // callers pass aligned base and whole-word count
  task automatic start(input logic [31:0] base, input logic [31:0] len);
    exp_addr = base;
    p_mark   = posts;
    axi_wr(OFS_BASE, base, RESP_OKAY);
    axi_wr(OFS_LEN, len, RESP_OKAY);
    axi_wr(OFS_CTRL, 32'h1, RESP_OKAY);
  endtask : start

  // bounded poll of the done bit
  task automatic wait_done;
    logic [31:0] v;
    int          n;
    v = 32'h0;
    n = 0;
    while (v[ST_DONE_BIT] !== 1'b1 && n < 300) begin
      axi_rd(OFS_STATUS, v);
      n++;
    end
    if (n >= 300) failures++;
  endtask : wait_done

  task automatic fifo_chk(input logic [31:0] base, input int words);
    for (int i = 0; i < words; i++) begin
      rd_chk(OFS_FIFO_DATA, (base + 32'(4 * i)) ^ KEY);
    end
  endtask : fifo_chk

  // port monitor: stall hold, address sequence, post timing
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (!resetn) begin
      held <= 1'b0;
    end else begin
      if (held) begin
        chk(mm_address, held_addr);
        chk({31'h0, mm_read}, 32'h1);
      end
      held      <= mm_read && mm_waitrequest;
      held_addr <= mm_address;
      if (mm_read) chk({28'h0, mm_byteenable}, {28'h0, BYTE_EN_ALL});
      if (mm_read && !mm_waitrequest) begin
        chk(mm_address, exp_addr);
        exp_addr <= exp_addr + WORD_BYTES;
        posts    <= posts + 1;
        if (posts == p_mark) t_first <= cyc;
        t_last <= cyc;
      end
    end
  end

  initial begin
    #100000;
    failures++;
    give_verdict;
  end

  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    // reset values, unmapped write, empty pop
    rd_chk(OFS_STATUS, 32'h4);
    rd_chk(OFS_IRQ_STAT, 32'h0);
    rd_chk(OFS_IRQ_MASK, 32'h0);
    rd_chk(OFS_BASE, RST_BASE);
    rd_chk(OFS_LEN, RST_LEN);
    axi_wr(8'h1c, 32'h1, RESP_SLVERR);
    rd_chk(8'h1c, 32'h0);
    rd_chk(OFS_FIFO_DATA, 32'h0);
    // eight words back to back
    start(32'h100, 32'h20);
    wait_done;
    chk(32'(posts - p_mark), 32'd8);
    chk(32'(t_last - t_first), 32'd7);
    rd_chk(OFS_STATUS, 32'h0801);
    fifo_chk(32'h100, 8);
    rd_chk(OFS_STATUS, 32'h5);
    // interrupt raise, mask, clear
    rd_chk(OFS_IRQ_STAT, 32'h3);
    chk({31'h0, irq}, 32'h0);
    axi_wr(OFS_IRQ_MASK, 32'h1, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    axi_wr(OFS_IRQ_STAT, 32'h1, RESP_OKAY);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd_chk(OFS_IRQ_STAT, 32'h2);
    axi_wr(OFS_IRQ_STAT, 32'h2, RESP_OKAY);
    // returns held back: posts stop at the threshold
    ret_en <= 1'b0;
    start(32'h200, 32'h40);
    repeat (40) @(posedge clk);
    chk(32'(posts - p_mark), 32'(THR));
    rd_chk(OFS_STATUS, 32'h6);
    ret_en <= 1'b1;
    repeat (40) @(posedge clk);
    chk(32'(posts - p_mark), 32'(THR));
    rd_chk(OFS_STATUS, 32'h0c02);
    fifo_chk(32'h200, 16);
    wait_done;
    chk(32'(posts - p_mark), 32'd16);
    // stalling slave with slow returns
    slow <= 1'b1;
    start(32'h180, 32'h10);
    wait_done;
    chk(32'(posts - p_mark), 32'd4);
    fifo_chk(32'h180, 4);
    slow <= 1'b0;
    // zero length finishes with no reads
    start(32'h300, 32'h0);
    wait_done;
    chk(32'(posts - p_mark), 32'd0);
    rd_chk(OFS_STATUS, 32'h5);
    give_verdict;
  end
endmodule : tb_prm_read_master
